// >>> rtl/ebt_pkg.sv
package ebt_pkg;

   localparam logic [9:0] EBT_IDX_CTRL    = 10'h01a;
   localparam logic [9:0] EBT_IDX_CMP     = 10'h01b;
   localparam logic [9:0] EBT_IDX_CFG     = 10'h01c;
   localparam logic [9:0] EBT_IDX_STATUS  = 10'h01d;

   localparam int         EBT_POS_MODE    = 0;
   localparam int         EBT_POS_CLKSEL  = 2;
   localparam int         EBT_POS_RUN     = 5;
   localparam int         EBT_POS_DOUBLE  = 0;
   localparam int         EBT_POS_CNT     = 0;
   localparam int         EBT_POS_DIVOUT  = 8;
   localparam int         EBT_POS_PWMOUT  = 9;

   localparam logic [7:0] EBT_RST_CMP     = 8'hff;
   localparam logic       EBT_RST_DOUBLE  = 1'b0;

   localparam logic [2:0] EBT_CLK_EXT     = 3'h7;
   localparam logic [7:0] EBT_CNT_TOP     = 8'hff;
   localparam int         EBT_DIV_W       = 13;

   localparam logic [3:0] EBT_EXP_SEL0    = 4'hb;
   localparam logic [3:0] EBT_EXP_SEL1    = 4'h7;
   localparam logic [3:0] EBT_EXP_SEL2    = 4'h5;
   localparam logic [3:0] EBT_EXP_SEL3    = 4'h3;
   localparam logic [3:0] EBT_EXP_SEL4    = 4'h2;
   localparam logic [3:0] EBT_EXP_SEL5    = 4'h1;
   localparam logic [3:0] EBT_EXP_SEL6    = 4'h0;

   typedef enum logic [1:0] {
      EBT_MODE_TIMER = 2'b00,
      EBT_MODE_RSVD  = 2'b01,
      EBT_MODE_PDO   = 2'b10,
      EBT_MODE_PWM   = 2'b11
   } ebt_mode_e;

   typedef struct packed {
      logic       run_control;
      logic [2:0] clock_select;
      ebt_mode_e  mode_select;
   } ebt_ctrl_s;

   localparam ebt_ctrl_s  EBT_RST_CTRL    = '{1'b0, 3'h0, EBT_MODE_TIMER};

endpackage

// >>> rtl/ebt_timer.sv
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module ebt_timer (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        event_in_pin,
   input  wire logic        stop_mode_entry,
   output logic             divider_out_pin,
   output logic             pwm_out_pin,
   output logic             timer_irq
);

   ebt_pkg::ebt_ctrl_s       ctrl;
   logic [7:0]               cmp;
   logic [7:0]               pwm_cmp;
   logic                     prescaler_double_select;
   logic [7:0]               cnt;
   logic [ebt_pkg::EBT_DIV_W-1:0] div;
   logic                     ev_s1;
   logic                     ev_s2;
   logic                     ev_s3;
   logic                     ev_lvl;
   logic                     ev_rise;
   logic                     ev_fall;
   logic                     tick;
   logic                     ext_src;
   logic [3:0]               shift;
   logic [ebt_pkg::EBT_DIV_W-1:0] mask;
   logic [7:0]               cnt_inc;
   logic                     wr_en;
   logic                     acc;
   logic [9:0]               idx;
   logic                     mapped;

   assign idx    = paddr[11:2];
   assign acc    = psel && penable;
   assign wr_en  = acc && pready && pwrite;
   assign mapped = (idx == ebt_pkg::EBT_IDX_CTRL) ||
                   (idx == ebt_pkg::EBT_IDX_CMP) ||
                   (idx == ebt_pkg::EBT_IDX_CFG) ||
                   (idx == ebt_pkg::EBT_IDX_STATUS);

   // The slave answers one cycle into the access phase.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc && !pready;
         pslverr <= acc && !pready && !mapped;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
      end else if (acc && !pready) begin
         prdata <= 32'h0000_0000;
         case (idx)
            ebt_pkg::EBT_IDX_CTRL: begin
               prdata[5:0] <= ctrl;
            end
            ebt_pkg::EBT_IDX_CMP: begin
               prdata[7:0] <= cmp;
            end
            ebt_pkg::EBT_IDX_CFG: begin
               prdata[ebt_pkg::EBT_POS_DOUBLE] <= prescaler_double_select;
            end
            ebt_pkg::EBT_IDX_STATUS: begin
               prdata[ebt_pkg::EBT_POS_CNT +: 8]  <= cnt;
               prdata[ebt_pkg::EBT_POS_DIVOUT]    <= divider_out_pin;
               prdata[ebt_pkg::EBT_POS_PWMOUT]    <= pwm_out_pin;
            end
            default: begin
               prdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl <= ebt_pkg::EBT_RST_CTRL;
      end else if (stop_mode_entry) begin
         ctrl.run_control <= 1'b0;
      end else if (wr_en && idx == ebt_pkg::EBT_IDX_CTRL) begin
         ctrl <= ebt_pkg::ebt_ctrl_s'(pwdata[5:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cmp                     <= ebt_pkg::EBT_RST_CMP;
         prescaler_double_select <= ebt_pkg::EBT_RST_DOUBLE;
      end else if (wr_en) begin
         if (idx == ebt_pkg::EBT_IDX_CMP) begin
            cmp <= pwdata[7:0];
         end
         if (idx == ebt_pkg::EBT_IDX_CFG) begin
            prescaler_double_select <= pwdata[ebt_pkg::EBT_POS_DOUBLE];
         end
      end
   end

   // The event pin is synchronised; a level counts once stages two and
   // three agree.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ev_s1  <= 1'b0;
         ev_s2  <= 1'b0;
         ev_s3  <= 1'b0;
         ev_lvl <= 1'b0;
      end else begin
         ev_s1 <= event_in_pin;
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
         if (ev_s2 == ev_s3) begin
            ev_lvl <= ev_s3;
         end
      end
   end

   assign ev_rise = (ev_s2 == ev_s3) && ev_s3 && !ev_lvl;
   assign ev_fall = (ev_s2 == ev_s3) && !ev_s3 && ev_lvl;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div <= '0;
      end else begin
         div <= div + 1'b1;
      end
   end

   always_comb begin
      case (ctrl.clock_select)
         3'h0:    shift = ebt_pkg::EBT_EXP_SEL0;
         3'h1:    shift = ebt_pkg::EBT_EXP_SEL1;
         3'h2:    shift = ebt_pkg::EBT_EXP_SEL2;
         3'h3:    shift = ebt_pkg::EBT_EXP_SEL3;
         3'h4:    shift = ebt_pkg::EBT_EXP_SEL4;
         3'h5:    shift = ebt_pkg::EBT_EXP_SEL5;
         default: shift = ebt_pkg::EBT_EXP_SEL6;
      endcase
      shift = shift + {3'h0, prescaler_double_select};
      mask  = ebt_pkg::EBT_DIV_W'((1 << shift) - 1);
   end

   assign ext_src = (ctrl.clock_select == ebt_pkg::EBT_CLK_EXT);
   assign tick    = ext_src ? ev_rise : ((div & mask) == mask);
   assign cnt_inc = cnt + 8'h01;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt       <= 8'h00;
         timer_irq <= 1'b0;
      end else if (!ctrl.run_control) begin
         cnt       <= 8'h00;
         timer_irq <= 1'b0;
      end else begin
         timer_irq <= 1'b0;
         case (ctrl.mode_select)
            ebt_pkg::EBT_MODE_TIMER: begin
               if (ext_src) begin
                  if (ev_fall && cnt == cmp) begin
                     cnt       <= 8'h00;
                     timer_irq <= 1'b1;
                  end else if (tick) begin
                     cnt <= cnt_inc;
                  end
               end else if (tick) begin
                  if (cnt_inc == cmp) begin
                     cnt       <= 8'h00;
                     timer_irq <= 1'b1;
                  end else begin
                     cnt <= cnt_inc;
                  end
               end
            end
            ebt_pkg::EBT_MODE_PDO: begin
               if (tick) begin
                  if (cnt_inc == cmp) begin
                     cnt       <= 8'h00;
                     timer_irq <= 1'b1;
                  end else begin
                     cnt <= cnt_inc;
                  end
               end
            end
            ebt_pkg::EBT_MODE_PWM: begin
               if (tick) begin
                  cnt       <= cnt_inc;
                  timer_irq <= (cnt == ebt_pkg::EBT_CNT_TOP);
               end
            end
            default: begin
               cnt <= 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         divider_out_pin <= 1'b1;
      end else if (!ctrl.run_control ||
                   ctrl.mode_select != ebt_pkg::EBT_MODE_PDO) begin
         divider_out_pin <= 1'b1;
      end else if (tick && cnt_inc == cmp) begin
         divider_out_pin <= !divider_out_pin;
      end
   end

   // PWM low on match, high on overflow
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwm_out_pin <= 1'b1;
      end else if (!ctrl.run_control ||
                   ctrl.mode_select != ebt_pkg::EBT_MODE_PWM) begin
         pwm_out_pin <= 1'b1;
      end else if (tick) begin
         if (cnt == ebt_pkg::EBT_CNT_TOP) begin
            pwm_out_pin <= 1'b1;
         end else if (cnt_inc == pwm_cmp) begin
            pwm_out_pin <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pwm_cmp <= ebt_pkg::EBT_RST_CMP;
      end else if (!ctrl.run_control) begin
         pwm_cmp <= cmp;
      end else if (tick && cnt == ebt_pkg::EBT_CNT_TOP) begin
         pwm_cmp <= cmp;
      end
   end

   chk_stop_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      !ctrl.run_control |=> (cnt == 8'h00))
      else $error("Counter not cleared while stopped.");

   chk_stop_high: assert property (
      @(posedge clk) disable iff (!rst_n)
      !ctrl.run_control |=> (divider_out_pin && pwm_out_pin))
      else $error("Output pin not high while stopped.");

   chk_stop_mode: assert property (
      @(posedge clk) disable iff (!rst_n)
      stop_mode_entry |=> !ctrl.run_control)
      else $error("Run bit survived stop mode entry.");

   chk_ctrl_read: assert property (
      @(posedge clk) disable iff (!rst_n)
      (acc && pready && !pwrite && idx == ebt_pkg::EBT_IDX_CTRL)
      |-> (prdata[31:6] == 26'h0 && prdata[5:0] == ctrl))
      else $error("Control read data wrong.");

   chk_timer_match: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctrl.run_control && ctrl.mode_select == ebt_pkg::EBT_MODE_TIMER &&
       !ext_src && tick && cnt_inc == cmp && !stop_mode_entry)
      |=> (timer_irq && cnt == 8'h00))
      else $error("Timer match did not interrupt and clear.");

   chk_event_count: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctrl.run_control && ext_src &&
       ctrl.mode_select == ebt_pkg::EBT_MODE_TIMER && ev_rise &&
       !stop_mode_entry && !(wr_en && idx == ebt_pkg::EBT_IDX_CTRL))
      |=> (cnt == $past(cnt_inc) && !timer_irq))
      else $error("Event rising edge not counted.");

   chk_pdo_toggle: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctrl.run_control && ctrl.mode_select == ebt_pkg::EBT_MODE_PDO &&
       $past(ctrl.run_control) && timer_irq)
      |-> (divider_out_pin != $past(divider_out_pin)))
      else $error("Divider output did not toggle on match.");

   chk_pwm_wrap: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctrl.run_control && ctrl.mode_select == ebt_pkg::EBT_MODE_PWM &&
       tick && cnt == ebt_pkg::EBT_CNT_TOP && !stop_mode_entry &&
       !(wr_en && idx == ebt_pkg::EBT_IDX_CTRL))
      |=> (timer_irq && pwm_out_pin && cnt == 8'h00 &&
           pwm_cmp == $past(cmp)))
      else $error("PWM overflow handling wrong.");

   chk_pwm_load: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctrl.run_control && $past(ctrl.run_control) &&
       !(tick && cnt == ebt_pkg::EBT_CNT_TOP))
      |=> (pwm_cmp == $past(pwm_cmp)))
      else $error("PWM compare changed mid period.");

endmodule

// >>> verif/ebt_evt_src.sv
`timescale 1ns/1ps
module ebt_evt_src (
   input  wire logic clk,
   output logic      event_in_pin
);
   initial event_in_pin = 1'b0;
   task automatic drive(input logic v, input int n);
      @(posedge clk);
      event_in_pin <= v;
      repeat ((n < 8) ? 8 : n) @(posedge clk);
   endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   localparam logic [11:0] A_CTRL = {ebt_pkg::EBT_IDX_CTRL, 2'h0};
   localparam logic [11:0] A_CMP  = {ebt_pkg::EBT_IDX_CMP, 2'h0};
   localparam logic [11:0] A_CFG  = {ebt_pkg::EBT_IDX_CFG, 2'h0};
   localparam logic [11:0] A_STAT = {ebt_pkg::EBT_IDX_STATUS, 2'h0};
   logic        clk             = 1'b0;
   logic        rst_n           = 1'b0;
   logic        psel            = 1'b0;
   logic        penable         = 1'b0;
   logic        pwrite          = 1'b0;
   logic [11:0] paddr           = 12'h000;
   logic [31:0] pwdata          = 32'h0;
   logic        stop_mode_entry = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        event_in_pin;
   logic        divider_out_pin;
   logic        pwm_out_pin;
   logic        timer_irq;
   logic [31:0] rd;
   logic        er;
   logic        b0;
   int          fail_count      = 0;
   int          checks          = 0;
   int          cyc             = 0;
   int          lows            = 0;
   int          nirq            = 0;
   int          t0;
   int          t1;
   int          l0;

   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pwm_out_pin === 1'b0) begin
         lows <= lows + 1;
      end
      if (timer_irq === 1'b1) begin
         nirq <= nirq + 1;
      end
   end

   ebt_timer DUT (
      .clk             (clk),
      .rst_n           (rst_n),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .prdata          (prdata),
      .pready          (pready),
      .pslverr         (pslverr),
      .event_in_pin    (event_in_pin),
      .stop_mode_entry (stop_mode_entry),
      .divider_out_pin (divider_out_pin),
      .pwm_out_pin     (pwm_out_pin),
      .timer_irq       (timer_irq)
   );

   ebt_evt_src src (
      .clk          (clk),
      .event_in_pin (event_in_pin)
   );

   function automatic logic [31:0] ctl(input logic r, input logic [2:0] s,
                                       input logic [1:0] m);
      return {26'h0, r, s, m};
   endfunction

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      if (k >= 20) begin
         chk("pready", 32'h1, 32'h0);
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wirq(output int t);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (timer_irq !== 1'b1 && k < 2000);
      if (k >= 2000) begin
         chk("irq", 32'h1, 32'h0);
      end
      t = cyc;
   endtask

   task conclude;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      conclude;
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl_rst", 32'h0, rd);
      apb(1'b0, A_CMP, 32'h0);
      chk("cmp_rst", 32'hff, rd);
      chk("pdo_idle", 32'h1, divider_out_pin);
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped", 32'h1, er);
      for (int d = 0; d < 2; d++) begin
         apb(1'b1, A_CFG, d);
         apb(1'b1, A_CMP, 32'h3);
         apb(1'b1, A_CTRL, ctl(1'b0, 3'h3, 2'h0));
         apb(1'b1, A_CTRL, ctl(1'b1, 3'h3, 2'h0));
         wirq(t0);
         wirq(t1);
         chk("timer_period", 24 << d, t1 - t0);
         apb(1'b1, A_CTRL, ctl(1'b0, 3'h3, 2'h0));
      end
      apb(1'b1, A_CFG, 32'h0);
      apb(1'b1, A_CMP, 32'h2);
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h3, 2'h2));
      apb(1'b1, A_CTRL, ctl(1'b1, 3'h3, 2'h2));
      wirq(t0);
      b0 = divider_out_pin;
      wirq(t1);
      chk("pdo_toggle", {31'h0, !b0}, divider_out_pin);
      chk("pdo_period", 32'h10, t1 - t0);
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h3, 2'h2));
      apb(1'b0, A_STAT, 32'h0);
      chk("stopped", 32'h300, rd);
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h3, 2'h1));
      apb(1'b1, A_CTRL, ctl(1'b1, 3'h3, 2'h1));
      l0 = nirq;
      repeat (40) @(posedge clk);
      apb(1'b0, A_STAT, 32'h0);
      chk("rsvd_stat", 32'h300, rd);
      chk("rsvd_irq", l0, nirq);
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h3, 2'h1));
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h7, 2'h0));
      apb(1'b1, A_CTRL, ctl(1'b1, 3'h7, 2'h0));
      l0 = nirq;
      src.drive(1'b1, 10);
      src.drive(1'b0, 10);
      src.drive(1'b1, 10);
      chk("evt_early", l0, nirq);
      src.drive(1'b0, 12);
      chk("evt_irq", l0 + 1, nirq);
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h7, 2'h0));
      apb(1'b1, A_CMP, 32'h80);
      apb(1'b1, A_CTRL, ctl(1'b0, 3'h5, 2'h3));
      apb(1'b1, A_CTRL, ctl(1'b1, 3'h5, 2'h3));
      wirq(t0);
      l0 = lows;
      apb(1'b1, A_CMP, 32'h40);
      wirq(t1);
      chk("pwm_period", 32'h200, t1 - t0);
      chk("pwm_low_old", 32'h100, lows - l0);
      l0 = lows;
      wirq(t0);
      chk("pwm_low_new", 32'h180, lows - l0);
      @(posedge clk);
      stop_mode_entry <= 1'b1;
      @(posedge clk);
      stop_mode_entry <= 1'b0;
      apb(1'b0, A_CTRL, 32'h0);
      chk("stop_ctrl", ctl(1'b0, 3'h5, 2'h3), rd);
      chk("pwm_idle", 32'h1, pwm_out_pin);
      conclude;
   end
endmodule
